// ### src/pmsc_pkg.sv
// Package: register map, field positions and state type of the power supervision block
package pmsc_pkg;

    // ----------------------------------------------------------------
    // Register word indices; byte offsets in the comments
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [5:0] IDX_SUPV = 6'h00; // power_supervision_control_status at 0x00
    localparam logic [5:0] IDX_LVL = 6'h01; // power_level_stop_control_status at 0x04
    localparam logic [5:0] IDX_IST = 6'h02; // event status at 0x08
    localparam logic [5:0] IDX_IMSK = 6'h03; // event mask at 0x0c

    // ----------------------------------------------------------------
    // Field positions, first register
    // ----------------------------------------------------------------
    localparam int unsigned B_WFLAG = 7;
    localparam int unsigned B_WACK = 6;
    localparam int unsigned B_WIE = 5;
    localparam int unsigned B_DRE = 4;
    localparam int unsigned B_DSE = 3;
    localparam int unsigned B_DE = 2;
    localparam int unsigned B_RBE = 0;

    // ----------------------------------------------------------------
    // Field positions, second register
    // ----------------------------------------------------------------
    localparam int unsigned B_DLV = 5;
    localparam int unsigned B_WLV = 4;
    localparam int unsigned B_PDF = 3;
    localparam int unsigned B_PDACK = 2;
    localparam int unsigned B_PDC = 0;

    // ----------------------------------------------------------------
    // Event bits of status and mask
    // ----------------------------------------------------------------
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_WARN = 0;
    localparam int unsigned EV_DET = 1;
    localparam int unsigned EV_REC = 2;
    localparam logic [2:0] RST_IMSK = 3'h0;

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // All state of the block
    typedef struct packed {
        logic wsync1;
        logic wsync2;
        logic dsync1;
        logic dsync2;
        logic dprev;
        logic wflag;
        logic wie;
        logic dre;
        logic dse;
        logic de;
        logic rbe;
        logic sup_once;
        logic dlv;
        logic wlv;
        logic lvl_once;
        logic pdf;
        logic pdc;
        logic pdc_once;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic aw_got;
        logic [5:0] aidx;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rst_req;
    } pmsc_state_t;

endpackage : pmsc_pkg

// ### src/pmsc_top.sv
// Power supervision and stop-mode control registers behind an AXI4-Lite slave
//
// How it works
// - Warning flag bit 7 reads 1 during warning and stays until acknowledged.
// - Warning input sets the flag, also right after any reset.
// - Writing 1 to bit 6 clears the flag only if warning is gone.
// - With bit 5 set, interrupt request is high while the flag is 1.
// - Write-once bit 4: detect event forces reset when detection enabled.
// - Bit 3 decides whether detection works during stop mode.
// - Write-once bit 2 enables detection and qualifies bits 4 and 3.
// - Bit 0 of first register drives the reference buffer enable.
// - Detect level bit 5 takes only the first write after power-on.
// - Warning level bit 4 picks one of two warning levels in range.
// - Detect:warning bits give four warning levels, detect bit two levels.
// - Read-only bit 3 is 1 after recovery from deep stop mode.
// - Writing 1 to bit 2 of second register clears the recovery flag.
// - Write-once bit 0 picks light (0) or deep (1) stop mode.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pmsc_top (
    input wire logic aclk, // Bus clock, 20 MHz
    input wire logic aresetn, // Any reset, synchronous, low
    input wire logic por_n, // Power-on reset, synchronous, low
    input wire logic [pmsc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [pmsc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic undervoltage_warning, // Warning comparator, async
    input wire logic undervoltage_detect, // Detect comparator, async
    input wire logic stop_mode, // Device is in stop mode
    input wire logic deep_stop_recovered, // Pulse: woke from deep stop
    output logic warning_irq, // Warning interrupt request
    output logic irq, // Unmasked event interrupt
    output logic detect_active, // Detect comparator enable
    output logic detect_reset_req, // Request device reset
    output logic reference_buffer_enable, // Reference buffer enable
    output logic detect_level_select, // Detect trip level select
    output logic warning_level_select, // Warning level select
    output logic power_down_control // 0 light stop, 1 deep stop
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Word index from a byte address
    function automatic logic [5:0] pmsc_idx(input logic [pmsc_pkg::ADDR_W-1:0] a);
        pmsc_idx = a[7:2];
    endfunction : pmsc_idx

    // Index belongs to the map
    function automatic logic pmsc_mapped(input logic [5:0] i);
        pmsc_mapped = (i <= pmsc_pkg::IDX_IMSK);
    endfunction : pmsc_mapped

    pmsc_pkg::pmsc_state_t st_ff;
    pmsc_pkg::pmsc_state_t nxt_st;

    logic det_on;
    logic det_event;
    logic warn_set;
    logic [7:0] supv_rd;
    logic [7:0] lvl_rd;
    logic do_wr;
    logic do_rd;
    logic [5:0] ridx;
    logic wlow;

    // ----------------------------------------------------------------
    // Combinational views
    // ----------------------------------------------------------------

    // Detection qualified by enable and stop mode
    assign det_on = st_ff.de & (~stop_mode | st_ff.dse);
    assign det_event = det_on & st_ff.dsync2 & ~st_ff.dprev;
    assign warn_set = st_ff.wsync2 & ~st_ff.wflag;

    // Register read images
    always_comb begin
        supv_rd = 8'h00;
        supv_rd[pmsc_pkg::B_WFLAG] = st_ff.wflag;
        supv_rd[pmsc_pkg::B_WIE] = st_ff.wie;
        supv_rd[pmsc_pkg::B_DRE] = st_ff.dre;
        supv_rd[pmsc_pkg::B_DSE] = st_ff.dse;
        supv_rd[pmsc_pkg::B_DE] = st_ff.de;
        supv_rd[pmsc_pkg::B_RBE] = st_ff.rbe;
        lvl_rd = 8'h00;
        lvl_rd[pmsc_pkg::B_DLV] = st_ff.dlv;
        lvl_rd[pmsc_pkg::B_WLV] = st_ff.wlv;
        lvl_rd[pmsc_pkg::B_PDF] = st_ff.pdf;
        lvl_rd[pmsc_pkg::B_PDC] = st_ff.pdc;
    end

    // Bus handshake terms
    assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
    assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
    assign s_axi_arready = ~st_ff.rvalid;
    assign do_wr = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
    assign do_rd = s_axi_arvalid & ~st_ff.rvalid;
    assign ridx = pmsc_idx(s_axi_araddr);
    assign wlow = st_ff.wstrb[0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Two-flop synchronisers and edge memory
        nxt_st.wsync1 = undervoltage_warning;
        nxt_st.wsync2 = st_ff.wsync1;
        nxt_st.dsync1 = undervoltage_detect;
        nxt_st.dsync2 = st_ff.dsync1;
        nxt_st.dprev = st_ff.dsync2;

        // Write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aidx = pmsc_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end

        // Register writes, low byte lane only
        if (do_wr) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = pmsc_mapped(st_ff.aidx) ? pmsc_pkg::RESP_OKAY
                                                  : pmsc_pkg::RESP_DECERR;
            if (wlow && st_ff.aidx == pmsc_pkg::IDX_SUPV) begin
                if (st_ff.wdata[pmsc_pkg::B_WACK] && !st_ff.wsync2) begin
                    nxt_st.wflag = 1'b0;
                end
                nxt_st.wie = st_ff.wdata[pmsc_pkg::B_WIE];
                nxt_st.dse = st_ff.wdata[pmsc_pkg::B_DSE];
                nxt_st.rbe = st_ff.wdata[pmsc_pkg::B_RBE];
                if (!st_ff.sup_once) begin
                    nxt_st.sup_once = 1'b1;
                    nxt_st.dre = st_ff.wdata[pmsc_pkg::B_DRE];
                    nxt_st.de = st_ff.wdata[pmsc_pkg::B_DE];
                end
            end else if (wlow && st_ff.aidx == pmsc_pkg::IDX_LVL) begin
                nxt_st.wlv = st_ff.wdata[pmsc_pkg::B_WLV];
                if (!st_ff.lvl_once) begin
                    nxt_st.lvl_once = 1'b1;
                    nxt_st.dlv = st_ff.wdata[pmsc_pkg::B_DLV];
                end
                if (st_ff.wdata[pmsc_pkg::B_PDACK]) begin
                    nxt_st.pdf = 1'b0;
                end
                if (!st_ff.pdc_once) begin
                    nxt_st.pdc_once = 1'b1;
                    nxt_st.pdc = st_ff.wdata[pmsc_pkg::B_PDC];
                end
            end else if (wlow && st_ff.aidx == pmsc_pkg::IDX_IMSK) begin
                nxt_st.imsk = st_ff.wdata[pmsc_pkg::EV_W-1:0];
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // Register reads; status clears on read
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (do_rd) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = pmsc_mapped(ridx) ? pmsc_pkg::RESP_OKAY
                                             : pmsc_pkg::RESP_DECERR;
            if (ridx == pmsc_pkg::IDX_SUPV) begin
                nxt_st.rdata[7:0] = supv_rd;
            end else if (ridx == pmsc_pkg::IDX_LVL) begin
                nxt_st.rdata[7:0] = lvl_rd;
            end else if (ridx == pmsc_pkg::IDX_IST) begin
                nxt_st.rdata[pmsc_pkg::EV_W-1:0] = st_ff.ist;
                nxt_st.ist = 3'h0;
            end else if (ridx == pmsc_pkg::IDX_IMSK) begin
                nxt_st.rdata[pmsc_pkg::EV_W-1:0] = st_ff.imsk;
            end
        end

        // Hardware sets win over any bus clear in the same cycle; the resets below still clear them
        if (st_ff.wsync2) begin
            nxt_st.wflag = 1'b1;
        end
        if (deep_stop_recovered) begin
            nxt_st.pdf = 1'b1;
        end
        if (warn_set) begin
            nxt_st.ist[pmsc_pkg::EV_WARN] = 1'b1;
        end
        if (det_event) begin
            nxt_st.ist[pmsc_pkg::EV_DET] = 1'b1;
        end
        if (deep_stop_recovered) begin
            nxt_st.ist[pmsc_pkg::EV_REC] = 1'b1;
        end

        // Reset request while an enabled detect is present
        nxt_st.rst_req = det_on & st_ff.dre & st_ff.dsync2;

        // Any reset: all but the power-on-only level fields
        if (!aresetn) begin
            nxt_st = '0;
            nxt_st.imsk = pmsc_pkg::RST_IMSK;
            nxt_st.dlv = st_ff.dlv;
            nxt_st.wlv = st_ff.wlv;
            nxt_st.lvl_once = st_ff.lvl_once;
        end
        // Power-on reset clears everything
        if (!por_n) begin
            nxt_st = '0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Bus answers from flip-flops
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    // Block controls and requests
    assign warning_irq = st_ff.wie & st_ff.wflag;
    assign irq = |(st_ff.ist & st_ff.imsk);
    assign detect_active = det_on;
    assign detect_reset_req = st_ff.rst_req;
    assign reference_buffer_enable = st_ff.rbe;
    assign detect_level_select = st_ff.dlv;
    assign warning_level_select = st_ff.wlv;
    assign power_down_control = st_ff.pdc;

endmodule : pmsc_top

`default_nettype wire

// ### test/pmsc_monitor.sv
// Checker: bus handshakes and supervision outputs of the power block
`timescale 1ns/1ps
`default_nettype none
module pmsc_monitor (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B resp
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_arready, // Ar ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic undervoltage_detect, // Detect input
    input wire logic stop_mode, // Stop mode
    input wire logic warning_irq, // Warning request
    input wire logic detect_active, // Detect enable
    input wire logic detect_reset_req, // Reset request
    input wire logic power_down_control // Stop select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Handshake and answer timing
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    // Supervision outputs tied to their causes
    AST_REQ_CAUSE: assert property (detect_reset_req |->
        $past(detect_active) && $past(undervoltage_detect, 3))
        else $error("reset request without enabled detect");
    // A fall caused by the reset itself is excluded
    AST_IRQ_STICKY: assert property ($fell(warning_irq) && $past(aresetn) |->
        $past(s_axi_wvalid) || s_axi_bvalid)
        else $error("warning request dropped without a write");
    AST_DET_FALL: assert property ($fell(detect_active) && $past(aresetn) |->
        $rose(stop_mode) || $past(s_axi_wvalid) || s_axi_bvalid)
        else $error("detect enable dropped without cause");
    AST_RST_OUT: assert property ($rose(aresetn) |-> !warning_irq && !detect_reset_req && !detect_active && !power_down_control)
        else $error("outputs not cleared by reset");

    // Main scenarios
    cover property (detect_reset_req);
    cover property ($rose(warning_irq));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : pmsc_monitor

bind pmsc_top pmsc_monitor pmsc_monitor_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .undervoltage_detect(undervoltage_detect), .stop_mode(stop_mode), .warning_irq(warning_irq),
    .detect_active(detect_active), .detect_reset_req(detect_reset_req),
    .power_down_control(power_down_control));
`default_nettype wire

// ### test/power_mgmt_status_control_tb_top.sv
// Testbench: register accesses and supervision events against expected values
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_status_control_tb_top;
    localparam logic [1:0] OK = pmsc_pkg::RESP_OKAY;
    localparam logic [1:0] DE = pmsc_pkg::RESP_DECERR;
    logic aclk, aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, undervoltage_warning, undervoltage_detect, stop_mode, deep_stop_recovered;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic warning_irq, irq, detect_active, detect_reset_req, reference_buffer_enable;
    logic detect_level_select, warning_level_select, power_down_control;
    int n_errors = 0;
    int cmp_count = 0;

    // Device under test
    pmsc_top pmsc_top_i (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .undervoltage_warning(undervoltage_warning), .undervoltage_detect(undervoltage_detect),
        .stop_mode(stop_mode), .deep_stop_recovered(deep_stop_recovered),
        .warning_irq(warning_irq), .irq(irq), .detect_active(detect_active),
        .detect_reset_req(detect_reset_req), .reference_buffer_enable(reference_buffer_enable),
        .detect_level_select(detect_level_select), .warning_level_select(warning_level_select),
        .power_down_control(power_down_control));

    // Clock, 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic bit_chk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bit_chk

    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    // Bus read with expected data and answer
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    // Two-cycle reset, optionally power-on as well
    task automatic rst_pulse(input logic por);
        aresetn <= 1'b0;
        por_n <= !por;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
    endtask : rst_pulse

    // Hang guard
    initial begin
        repeat (3000) @(posedge aclk);
        n_errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, undervoltage_detect, stop_mode, deep_stop_recovered} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        undervoltage_warning = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(8'h00, 32'h80, OK);
        bit_chk(warning_irq, 1'b0);
        wr(8'h00, 8'h75, OK);
        rd(8'h00, 32'hb5, OK);
        rd(8'h08, 32'h1, OK);
        rd(8'h08, 32'h0, OK);
        wr(8'h0c, 8'h01, OK);
        wr(8'h00, 8'h35, OK);
        @(negedge aclk);
        bit_chk(warning_irq, 1'b1);
        bit_chk(reference_buffer_enable, 1'b1);
        bit_chk(detect_active, 1'b1);
        @(posedge aclk);
        undervoltage_warning <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(8'h00, 8'h61, OK);
        rd(8'h00, 32'h35, OK);
        bit_chk(warning_irq, 1'b0);
        undervoltage_warning <= 1'b1;
        repeat (5) @(posedge aclk);
        bit_chk(warning_irq, 1'b1);
        bit_chk(irq, 1'b1);
        undervoltage_warning <= 1'b0;
        rd(8'h08, 32'h1, OK);
        stop_mode <= 1'b1;
        @(negedge aclk);
        bit_chk(irq, 1'b0);
        bit_chk(detect_active, 1'b0);
        wr(8'h00, 8'h29, OK);
        bit_chk(detect_active, 1'b1);
        undervoltage_detect <= 1'b1;
        repeat (4) @(posedge aclk);
        bit_chk(detect_reset_req, 1'b1);
        stop_mode <= 1'b0;
        undervoltage_detect <= 1'b0;
        rd(8'h08, 32'h2, OK);
        rst_pulse(1'b0);
        wr(8'h00, 8'h10, OK);
        wr(8'h00, 8'h04, OK);
        undervoltage_detect <= 1'b1;
        repeat (4) @(posedge aclk);
        bit_chk(detect_active, 1'b0);
        bit_chk(detect_reset_req, 1'b0);
        undervoltage_detect <= 1'b0;
        rd(8'h00, 32'h10, OK);
        wr(8'h04, 8'h31, OK);
        bit_chk(detect_level_select, 1'b1);
        bit_chk(warning_level_select, 1'b1);
        bit_chk(power_down_control, 1'b1);
        wr(8'h04, 8'h00, OK);
        rd(8'h04, 32'h21, OK);
        deep_stop_recovered <= 1'b1;
        @(posedge aclk);
        deep_stop_recovered <= 1'b0;
        rd(8'h04, 32'h29, OK);
        rd(8'h08, 32'h4, OK);
        wr(8'h04, 8'h04, OK);
        rd(8'h04, 32'h21, OK);
        rst_pulse(1'b0);
        rd(8'h04, 32'h20, OK);
        wr(8'h04, 8'h01, OK);
        rd(8'h04, 32'h21, OK);
        rst_pulse(1'b1);
        wr(8'h04, 8'h10, OK);
        rd(8'h04, 32'h10, OK);
        rd(8'h10, 32'h0, DE);
        wr(8'h20, 8'hff, DE);
        finish_test();
    end
endmodule : power_mgmt_status_control_tb_top
`default_nettype wire
